// *** rtl/pwr_seq_pkg.sv ***
package pwr_seq_pkg;

    // Clock period of clock_i
    localparam int CLK_PERIOD_NS    = 50;

    // Protocol times in microseconds
    localparam int T_SNK_TRANS_US   = 25000;
    localparam int T_SRC_READY_US   = 275000;

    // Least time rounds up, longest time rounds down
    localparam int SNK_TRANS_CYC    =
        (T_SNK_TRANS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SRC_READY_CYC    = (T_SRC_READY_US * 1000) / CLK_PERIOD_NS;

    localparam int CNT_W            = 24;
    localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARMED,
        ST_ACC_ACK,
        ST_SNK_WAIT,
        ST_SRC_WAIT,
        ST_PSRDY_ACK
    } seq_state_e;

    // Events from the protocol layer, one-cycle pulses
    typedef struct packed {
        logic request;
        logic goodcrc;
    } pd_rx_s;

    // Message requests to the protocol layer, one-cycle pulses
    typedef struct packed {
        logic ps_rdy;
    } pd_tx_s;

endpackage : pwr_seq_pkg

// *** rtl/power_level_transition_sequencer.sv ***
// What this block does
// - After Accept GoodCRC, source waits tSnkTransition before supply command.
// - After tSnkTransition, source commands the supply to new voltage.
// - Source supply is ready within tSrcReady after the command.
// - Supply readiness is reported and passed on to the source sequencer.
// - On supply readiness, source sends PS_RDY to the sink.
// - GoodCRC from sink for PS_RDY ends the source sequence.
// - The transition begins only after the sink has sent a Request.
`timescale 1ns/100ps
module power_level_transition_sequencer
    import pwr_seq_pkg::*;
#(
    parameter int SNK_CYC = SNK_TRANS_CYC,
    parameter int SRC_CYC = SRC_READY_CYC
) (
    // Clock and reset
    input  wire logic   clock_i,
    input  wire logic   rst_i,
    // Protocol layer
    input  wire pd_rx_s rx_i,
    input  wire logic   accept_sent_i,
    output      pd_tx_s tx_o,
    // Device policy manager and supply
    input  wire logic   supply_ready_i,
    output      logic   change_cmd_o,
    // Status
    output      logic   busy_o,
    output      logic   done_o,
    output      logic   fault_o
);

    localparam logic [CNT_W-1:0] SNK_LAST = CNT_W'(SNK_CYC - 1);
    localparam logic [CNT_W-1:0] SRC_LAST = CNT_W'(SRC_CYC - 1);

    seq_state_e       state_r;
    logic [CNT_W-1:0] cnt_r;
    logic             change_cmd_r;
    logic             ps_rdy_r;
    logic             done_r;
    logic             fault_r;

    // Sequence state
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (rx_i.request) begin
                        state_r <= ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    if (accept_sent_i) begin
                        state_r <= ST_ACC_ACK;
                    end
                end
                ST_ACC_ACK: begin
                    if (rx_i.goodcrc) begin
                        state_r <= ST_SNK_WAIT;
                    end
                end
                ST_SNK_WAIT: begin
                    if (cnt_r == SNK_LAST) begin
                        state_r <= ST_SRC_WAIT;
                    end
                end
                ST_SRC_WAIT: begin
                    if (supply_ready_i) begin
                        state_r <= ST_PSRDY_ACK;
                    end else if (cnt_r == SRC_LAST) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_PSRDY_ACK: begin
                    if (rx_i.goodcrc) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Interval counter, restarted on each timed state entry
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cnt_r <= CNT_RST;
        end else if (state_r == ST_SNK_WAIT && cnt_r != SNK_LAST) begin
            cnt_r <= cnt_r + 1'b1;
        end else if (state_r == ST_SRC_WAIT && cnt_r != SRC_LAST) begin
            cnt_r <= cnt_r + 1'b1;
        end else begin
            cnt_r <= CNT_RST;
        end
    end

    // Registered one-cycle outputs
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            change_cmd_r <= 1'b0;
            ps_rdy_r     <= 1'b0;
            done_r       <= 1'b0;
            fault_r      <= 1'b0;
        end else begin
            change_cmd_r <= (state_r == ST_SNK_WAIT) && (cnt_r == SNK_LAST);
            ps_rdy_r     <= (state_r == ST_SRC_WAIT) && supply_ready_i;
            done_r       <= (state_r == ST_PSRDY_ACK) && rx_i.goodcrc;
            fault_r      <= (state_r == ST_SRC_WAIT) && !supply_ready_i
                            && (cnt_r == SRC_LAST);
        end
    end

    assign change_cmd_o = change_cmd_r;
    assign tx_o.ps_rdy  = ps_rdy_r;
    assign done_o       = done_r;
    assign fault_o      = fault_r;
    assign busy_o       = (state_r != ST_IDLE);

    AST_REQ_FIRST: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (state_r == ST_IDLE && !rx_i.request) |=> state_r == ST_IDLE)
        else $error("sequence left idle without a Request");

    AST_SNK_WAIT_FULL: assert property (
        @(posedge clock_i) disable iff (rst_i)
        change_cmd_o |-> $past(state_r) == ST_SNK_WAIT
                         && $past(cnt_r) == SNK_LAST)
        else $error("supply command before full sink wait");

    AST_NO_EARLY_CMD: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (state_r == ST_SNK_WAIT && cnt_r != SNK_LAST) |=> !change_cmd_o)
        else $error("supply command issued early");

    AST_CMD_ISSUED: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (state_r == ST_SNK_WAIT && cnt_r == SNK_LAST)
            |=> change_cmd_o && state_r == ST_SRC_WAIT && cnt_r == CNT_RST)
        else $error("supply command missing after sink wait");

    AST_SRC_BOUND: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (state_r == ST_SRC_WAIT && cnt_r == SRC_LAST && !supply_ready_i)
            |=> fault_o && state_r == ST_IDLE)
        else $error("supply readiness deadline not enforced");

    AST_PSRDY_CAUSE: assert property (
        @(posedge clock_i) disable iff (rst_i)
        tx_o.ps_rdy |-> $past(supply_ready_i)
                        && $past(state_r) == ST_SRC_WAIT)
        else $error("PS_RDY without supply readiness");

    AST_READY_SENDS: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (state_r == ST_SRC_WAIT && supply_ready_i)
            |=> tx_o.ps_rdy && state_r == ST_PSRDY_ACK)
        else $error("PS_RDY not sent on readiness");

    AST_DONE_ON_ACK: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (state_r == ST_PSRDY_ACK && rx_i.goodcrc)
            |=> done_o && state_r == ST_IDLE ##1 !done_o)
        else $error("GoodCRC for PS_RDY did not end sequence");

    AST_RESET_QUIET: assert property (
        @(posedge clock_i)
        $past(rst_i) |-> !change_cmd_o && !tx_o.ps_rdy && !done_o
                         && !fault_o && !busy_o)
        else $error("outputs not quiet after reset");

    AST_ONE_PULSE_CMD: assert property (
        @(posedge clock_i) disable iff (rst_i)
        change_cmd_o |=> !change_cmd_o)
        else $error("supply command longer than one cycle");

    AST_ONE_PULSE_PSRDY: assert property (
        @(posedge clock_i) disable iff (rst_i)
        tx_o.ps_rdy |=> !tx_o.ps_rdy)
        else $error("PS_RDY request longer than one cycle");

    AST_ARMED_HOLD: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (state_r == ST_ARMED && !accept_sent_i) |=> state_r == ST_ARMED)
        else $error("armed state left without Accept");

    AST_ACC_ACK_HOLD: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (state_r == ST_ACC_ACK && !rx_i.goodcrc) |=> state_r == ST_ACC_ACK)
        else $error("sink wait started without GoodCRC");

    AST_FAULT_CAUSE: assert property (
        @(posedge clock_i) disable iff (rst_i)
        fault_o |-> $past(state_r) == ST_SRC_WAIT && !$past(supply_ready_i)
                    && $past(cnt_r) == SRC_LAST)
        else $error("fault without missed readiness deadline");

    AST_SRC_CNT_RANGE: assert property (
        @(posedge clock_i) disable iff (rst_i)
        state_r == ST_SRC_WAIT |-> cnt_r <= SRC_LAST)
        else $error("readiness counter past its deadline");

    AST_DONE_CAUSE: assert property (
        @(posedge clock_i) disable iff (rst_i)
        done_o |-> $past(state_r) == ST_PSRDY_ACK && $past(rx_i.goodcrc))
        else $error("done without GoodCRC for PS_RDY");

    AST_ONE_OUT: assert property (
        @(posedge clock_i) disable iff (rst_i)
        $onehot0({change_cmd_o, tx_o.ps_rdy, done_o, fault_o}))
        else $error("more than one output pulse at once");

endmodule : power_level_transition_sequencer

// *** testbench/sink_peer_model.sv ***
`timescale 1ns/100ps
module sink_peer_model
    import pwr_seq_pkg::*;
(
    // Clock and reset
    input  wire logic   clock_i,
    input  wire logic   rst_i,
    // Stimulus and source side
    input  wire logic   send_req_i,
    input  wire logic   accept_i,
    input  wire pd_tx_s tx_i,
    input  wire logic   slow_i,
    // Messages to the source
    output      pd_rx_s rx_o
);
    logic req_r   = 1'b0;
    int   ack_r   = 0;
    int   timer_r = 0;
    logic stdby_r = 1'b0;
    initial rx_o = '0;
    always @(posedge clock_i) begin
        req_r <= send_req_i && !rst_i;
        if (rst_i) ack_r <= 0;
        else if (accept_i || tx_i.ps_rdy) ack_r <= slow_i ? 5 : 1;
        else if (ack_r != 0) ack_r <= ack_r - 1;
        if (rst_i || tx_i.ps_rdy) timer_r <= 0;
        else if (accept_i) timer_r <= 1;
        else if (timer_r != 0) timer_r <= timer_r + 1;
        // standby early, new level after PS_RDY
        if (rst_i || tx_i.ps_rdy) stdby_r <= 1'b0;
        else if (timer_r == 2) stdby_r <= 1'b1;
    end
    always @(negedge clock_i) begin
        rx_o.request <= req_r;
        rx_o.goodcrc <= ack_r == 1;
    end
endmodule : sink_peer_model

// *** testbench/power_level_transition_sequencer_tb.sv ***
`timescale 1ns/100ps
module power_level_transition_sequencer_tb
    import pwr_seq_pkg::*;
;
    localparam int SNK = 8;
    localparam int SRC = 16;
    logic        clock_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        accept_sent_i = 1'b0;
    logic        supply_ready_i = 1'b0;
    logic        send_req = 1'b0;
    logic        slow = 1'b0;
    pd_rx_s      rx;
    pd_tx_s      tx_o;
    logic        change_cmd_o, busy_o, done_o, fault_o;
    int          cyc = 0;
    int          fail_count = 0;
    int          tests_run = 0;
    logic [31:0] exp_q[$];
    always #25 clock_i = ~clock_i;
    always @(negedge clock_i) cyc++;
    power_level_transition_sequencer #(.SNK_CYC(SNK), .SRC_CYC(SRC)) u_dut (
        .clock_i(clock_i), .rst_i(rst_i), .rx_i(rx),
        .accept_sent_i(accept_sent_i), .tx_o(tx_o),
        .supply_ready_i(supply_ready_i), .change_cmd_o(change_cmd_o),
        .busy_o(busy_o), .done_o(done_o), .fault_o(fault_o));
    sink_peer_model u_peer (
        .clock_i(clock_i), .rst_i(rst_i), .send_req_i(send_req),
        .accept_i(accept_sent_i), .tx_i(tx_o), .slow_i(slow), .rx_o(rx));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    function automatic logic [31:0] note(input logic [3:0] k, input int c);
        return {k, c[27:0]};
    endfunction : note
    // Output pulses: kind {fault, done, ps_rdy, change} and cycle
    always @(posedge clock_i) begin
        if (!rst_i && (tx_o.ps_rdy | change_cmd_o | done_o | fault_o)) begin
            if (exp_q.size() == 0) check(32'h1, 32'h0);
            else check(note({fault_o, done_o, tx_o.ps_rdy, change_cmd_o}, cyc),
                       exp_q.pop_front());
        end
    end
    task automatic wait_ev(input logic sel, output int c);
        int n;
        for (n = 0; n < 64; n++) begin
            @(posedge clock_i);
            if (sel ? change_cmd_o === 1'b1 : rx.goodcrc === 1'b1) break;
        end
        c = cyc;
        if (n == 64) begin
            fail_count++;
            test_done();
        end
    endtask : wait_ev
    task automatic run(input int d, input logic s, input logic flt);
        int c;
        slow = s;
        @(negedge clock_i) send_req = 1'b1;
        @(negedge clock_i) send_req = 1'b0;
        @(negedge clock_i) accept_sent_i = 1'b1;
        check(busy_o, 1'b1);
        @(negedge clock_i) accept_sent_i = 1'b0;
        wait_ev(1'b0, c);
        exp_q.push_back(note(4'h1, c + SNK + 1));
        wait_ev(1'b1, c);
        check(u_peer.stdby_r, 1'b1);
        if (flt) begin
            exp_q.push_back(note(4'h8, c + SRC));
            repeat (SRC + 2) @(posedge clock_i);
        end else begin
            repeat (d - 1) @(posedge clock_i);
            @(negedge clock_i) supply_ready_i = 1'b1;
            exp_q.push_back(note(4'h2, c + d + 1));
            @(negedge clock_i) supply_ready_i = 1'b0;
            wait_ev(1'b0, c);
            exp_q.push_back(note(4'h4, c + 1));
            check(u_peer.stdby_r, 1'b0);
            check(u_peer.timer_r, 0);
            repeat (3) @(posedge clock_i);
        end
        @(negedge clock_i) check(busy_o, 1'b0);
        $display("test end at cycle %0d", cyc);
    endtask : run
    initial begin
        void'($urandom(52218));
        repeat (6) @(posedge clock_i);
        @(negedge clock_i) rst_i = 1'b0;
        run(1, 1'b0, 1'b0);
        run(SRC - 1, 1'b1, 1'b0);
        run(1 + $urandom % (SRC - 1), 1'(($urandom % 2)), 1'b0);
        run(0, 1'b0, 1'b1);
        @(negedge clock_i) accept_sent_i = 1'b1;
        @(negedge clock_i) accept_sent_i = 1'b0;
        repeat (3) @(negedge clock_i);
        check(busy_o, 1'b0);
        check(exp_q.size(), 0);
        $display("test end at cycle %0d", cyc);
        test_done();
    end
endmodule : power_level_transition_sequencer_tb
